/* File: aec_pkg.sv */
// Package with register offsets, reset values and limits of the exposure controller.
package aec_pkg;
  localparam logic [6:0] FINE_OFFSET = 7'h21;
  localparam logic [6:0] COARSE_OFFSET = 7'h23;
  localparam logic [6:0] GAIN_OFFSET = 7'h24;
  localparam logic [7:0] FINE_RESET = 8'h00;
  localparam logic [7:0] COARSE_RESET = 8'h70;
  localparam logic [2:0] GAIN_RESET = 3'h0;
  localparam logic [7:0] FINE_MAX_50 = 8'hff;
  localparam logic [7:0] FINE_MAX_60 = 8'ha8;
  localparam logic [7:0] COARSE_MAX = 8'h91;
  localparam logic [7:0] COARSE_MIN = 8'h00;
  localparam int PENDING_BIT = 0;
  localparam int DIV_BITS = 2;
  localparam int DIV_CNT_W = 4;
  localparam logic [7:0] LOWER_THR_RESET = 8'd85;
  localparam logic [7:0] CENTRE_THR_RESET = 8'd100;
  localparam logic [7:0] HIGHER_THR_RESET = 8'd115;
  localparam logic [7:0] CLAMP_COARSE_DEF = 8'h80;
  localparam logic [7:0] CLAMP_FINE_DEF = 8'h00;
  localparam logic [7:0] FINE_STEP = 8'h01;
  localparam logic [7:0] COARSE_STEP = 8'h01;
  localparam logic [15:0] DECIDE_MIN = 16'h0010;
  typedef enum logic [3:0] {
    AEC_VERY_OVER = 4'b0001,
    AEC_OVER = 4'b0010,
    AEC_UNDER = 4'b0100,
    AEC_VERY_UNDER = 4'b1000
  } aec_region_t;
endpackage

/* File: aec_pix_div.sv */
// Pixel-rate enable divider from the crystal clock.
`timescale 1ns/1ns
module aec_pix_div (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [aec_pkg::DIV_BITS-1:0] divisor,
  output logic pixEn
);
  typedef struct packed {
    logic [aec_pkg::DIV_CNT_W-1:0] cnt;
    logic en;
  } aec_div_t;
  aec_div_t s_q, s_d;
  logic [aec_pkg::DIV_CNT_W-1:0] last;

  // Period is two to the power (divisor + 1) crystal cycles.
  assign last = aec_pkg::DIV_CNT_W'((1 << (divisor + 1)) - 1); // R15

  always_comb begin
    s_d = s_q;
    s_d.en = 1'b0;
    if (s_q.cnt >= last) begin
      s_d.cnt = '0;
      s_d.en = 1'b1; // R2
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pixEn = s_q.en;
endmodule

/* File: aec_core.sv */
// Automatic exposure and gain controller with host-visible exposure registers.
`timescale 1ns/1ns
// Operation
// R1: With auto exposure on, pixels are watched and fine and coarse are adjusted.
// R2: Integration time stretches as the divided pixel clock slows.
// R3: Manual gain writes are accepted while exposure runs automatically.
// R4: Host should disable automatic control before writing that parameter.
// R5: Written coarse, fine and gain are taken only at a frame start.
// R6: Reads return the written value not yet consumed.
// R7: Status bit 0 stays set from write until consumption.
// R8: Written gain is applied one frame after coarse and fine.
// R9: Three thresholds split pixels into four regions that steer the next exposure.
// R10: With clamping on and coarse above a limit, fine is forced to a value.
// R11: Fine is 8 bits, resets to 00, maximum FF at 50Hz, A8 at 60Hz.
// R12: Coarse is 8 bits, resets to 70, maximum 91.
// R13: Gain is 3 bits, resets to zero, all eight codes writable.
// R14: Automatic gain uses only codes 000, 001, 011 and 111.
// R15: Pixel clock is crystal divided by two to the divisor plus one.
// R16: Pending clears only after all written values, gain included, are consumed.
module aec_core #(
  parameter int CNT_W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic frameStart,
  input wire logic pixValid,
  input wire logic [7:0] pixData,
  input wire logic autoExpEn,
  input wire logic autoGainEn,
  input wire logic clampEn,
  input wire logic mode60,
  input wire logic [aec_pkg::DIV_BITS-1:0] clkDivisor,
  input wire logic [7:0] lowerThr,
  input wire logic [7:0] centreThr,
  input wire logic [7:0] higherThr,
  input wire logic [7:0] clampCoarse,
  input wire logic [7:0] clampFine,
  output logic [7:0] fineActive,
  output logic [7:0] coarseActive,
  output logic [2:0] gainActive,
  output logic [7:0] statusReg,
  output logic [3:0] regionFlags,
  output logic pixEn
);
  typedef struct packed {
    logic [7:0] fineW;
    logic [7:0] coarseW;
    logic [2:0] gainW;
    logic fineNew;
    logic coarseNew;
    logic gainNew;
    logic [2:0] gainStage;
    logic gainStageNew;
    logic [7:0] fine;
    logic [7:0] coarse;
    logic [2:0] gain;
    logic [CNT_W-1:0] cVeryOver;
    logic [CNT_W-1:0] cOver;
    logic [CNT_W-1:0] cUnder;
    logic [CNT_W-1:0] cVeryUnder;
    logic [3:0] flags;
    logic [7:0] rdata;
  } aec_state_t;
  aec_state_t s_q, s_d;
  logic pixEnSync, pixStrobe;
  logic [7:0] fineMax, nextFine, nextCoarse;
  logic [2:0] nextGain;
  logic [3:0] region;

  aec_pix_div u_div (
    .mclk(mclk),
    .rst(rst),
    .divisor(clkDivisor),
    .pixEn(pixEnSync)
  );

  // Pixels are sampled only on pixel-rate enables, so a slower divisor counts fewer pixels in each frame.
  assign pixStrobe = pixValid && pixEnSync; // R2

  assign fineMax = mode60 ? aec_pkg::FINE_MAX_60 : aec_pkg::FINE_MAX_50; // R11

  always_comb begin
    if (pixData >= higherThr) begin
      region = aec_pkg::AEC_VERY_OVER;
    end else if (pixData >= centreThr) begin
      region = aec_pkg::AEC_OVER;
    end else if (pixData >= lowerThr) begin
      region = aec_pkg::AEC_UNDER;
    end else begin
      region = aec_pkg::AEC_VERY_UNDER;
    end
  end

  // Decide the next automatic settings from the frame's histogram.
  always_comb begin
    logic overWins;
    logic underWins;
    logic [3:0] fl;
    overWins = (s_q.cVeryOver + s_q.cOver) > (s_q.cUnder + s_q.cVeryUnder)
      && (s_q.cVeryOver + s_q.cOver) >= aec_pkg::DECIDE_MIN;
    underWins = (s_q.cUnder + s_q.cVeryUnder) > (s_q.cVeryOver + s_q.cOver)
      && (s_q.cUnder + s_q.cVeryUnder) >= aec_pkg::DECIDE_MIN;
    fl = {underWins && s_q.cVeryUnder > s_q.cUnder, underWins,
      overWins, overWins && s_q.cVeryOver > s_q.cOver}; // R9
    nextFine = s_q.fine;
    nextCoarse = s_q.coarse;
    nextGain = s_q.gain;
    if (fl[1]) begin
      if (s_q.fine > aec_pkg::COARSE_MIN) begin
        nextFine = s_q.fine - aec_pkg::FINE_STEP;
      end else if (s_q.coarse > aec_pkg::COARSE_MIN) begin
        nextCoarse = s_q.coarse - aec_pkg::COARSE_STEP;
        nextFine = fineMax;
      end
      // A manually written non-thermometer code is folded back onto the thermometer ladder.
      if (autoGainEn && s_q.coarse == aec_pkg::COARSE_MIN) begin
        nextGain = {1'b0, s_q.gain[2] & s_q.gain[1], s_q.gain[1]}; // R14
      end
    end else if (fl[2]) begin
      if (s_q.fine < fineMax) begin
        nextFine = s_q.fine + aec_pkg::FINE_STEP;
      end else if (s_q.coarse < aec_pkg::COARSE_MAX) begin
        nextCoarse = s_q.coarse + aec_pkg::COARSE_STEP; // R12
        nextFine = aec_pkg::COARSE_MIN;
      end else if (autoGainEn) begin
        nextGain = {s_q.gain[1], s_q.gain[1] | s_q.gain[0], 1'b1}; // R14
      end
    end
    // Clamping overrides whatever fine value the step logic chose.
    if (clampEn && nextCoarse > clampCoarse) begin
      nextFine = clampFine; // R10
    end
    if (nextFine > fineMax) begin
      nextFine = fineMax; // R11
    end
  end

  always_comb begin
    s_d = s_q;
    if (pixStrobe) begin
      unique case (region)
        aec_pkg::AEC_VERY_OVER: s_d.cVeryOver = s_q.cVeryOver + 1'b1;
        aec_pkg::AEC_OVER: s_d.cOver = s_q.cOver + 1'b1;
        aec_pkg::AEC_UNDER: s_d.cUnder = s_q.cUnder + 1'b1;
        default: s_d.cVeryUnder = s_q.cVeryUnder + 1'b1;
      endcase
    end
    if (frameStart) begin
      s_d.cVeryOver = '0;
      s_d.cOver = '0;
      s_d.cUnder = '0;
      s_d.cVeryUnder = '0;
      s_d.flags = {s_q.cVeryUnder > s_q.cUnder, s_q.cUnder != '0,
        s_q.cOver != '0, s_q.cVeryOver > s_q.cOver}; // R9
      if (autoExpEn) begin
        s_d.fine = nextFine; // R1
        s_d.coarse = nextCoarse;
        s_d.gain = nextGain;
      end
      // A switch to 60Hz timing pulls a larger held fine value down to the new maximum.
      if (s_d.fine > fineMax) begin
        s_d.fine = fineMax; // R11
      end
      // Staged gain lands one frame after its write was taken.
      if (s_q.gainStageNew) begin
        s_d.gain = s_q.gainStage; // R8
        s_d.gainStageNew = 1'b0;
      end
      if (s_q.fineNew) begin
        s_d.fine = (s_q.fineW > fineMax) ? fineMax : s_q.fineW; // R5
        s_d.fineNew = 1'b0;
      end
      if (s_q.coarseNew) begin
        s_d.coarse = (s_q.coarseW > aec_pkg::COARSE_MAX) ? aec_pkg::COARSE_MAX
          : s_q.coarseW; // R5
        s_d.coarseNew = 1'b0;
      end
      if (s_q.gainNew) begin
        s_d.gainStage = s_q.gainW; // R8
        s_d.gainStageNew = 1'b1;
        s_d.gainNew = 1'b0;
      end
    end
    // A write in the frame-start cycle wins over consumption.
    if (regWrite) begin
      unique case (regAddr)
        aec_pkg::FINE_OFFSET: begin
          s_d.fineW = regWdata;
          s_d.fineNew = 1'b1; // R7
        end
        aec_pkg::COARSE_OFFSET: begin
          s_d.coarseW = regWdata;
          s_d.coarseNew = 1'b1; // R7
        end
        aec_pkg::GAIN_OFFSET: begin
          s_d.gainW = regWdata[2:0]; // R13
          s_d.gainNew = 1'b1; // R3
        end
        default: begin
        end
      endcase
    end
    unique case (regAddr)
      aec_pkg::FINE_OFFSET: s_d.rdata = s_d.fineW; // R6
      aec_pkg::COARSE_OFFSET: s_d.rdata = s_d.coarseW; // R6
      aec_pkg::GAIN_OFFSET: s_d.rdata = {5'h00, s_d.gainW}; // R6
      default: s_d.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
      s_q.fineW <= aec_pkg::FINE_RESET; // R11
      s_q.coarseW <= aec_pkg::COARSE_RESET; // R12
      s_q.gainW <= aec_pkg::GAIN_RESET; // R13
      s_q.fine <= aec_pkg::FINE_RESET;
      s_q.coarse <= aec_pkg::COARSE_RESET;
      s_q.gain <= aec_pkg::GAIN_RESET;
      s_q.rdata <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdata = s_q.rdata;
  assign fineActive = s_q.fine;
  assign coarseActive = s_q.coarse;
  assign gainActive = s_q.gain;
  assign regionFlags = s_q.flags;
  assign pixEn = pixEnSync;
  // Pending covers the staged gain too, so it drops only when nothing is left.
  assign statusReg = {7'h00, s_q.fineNew | s_q.coarseNew | s_q.gainNew
    | s_q.gainStageNew}; // R7 R16

  a_pend_set: assert property (@(posedge mclk) disable iff (rst) // R7
    regWrite && regAddr == aec_pkg::FINE_OFFSET |=> statusReg[aec_pkg::PENDING_BIT])
    else $error("pending flag not set after fine write");
  a_fine_hold: assert property (@(posedge mclk) disable iff (rst) // R5
    !frameStart |=> $stable(fineActive))
    else $error("fine changed outside frame start");
  a_gain_late: assert property (@(posedge mclk) disable iff (rst) // R8
    frameStart && s_q.gainNew && !s_q.gainStageNew |=> gainActive == $past(gainActive)
    || autoExpEn) else $error("gain applied too early");
  a_gain_hold: assert property (@(posedge mclk) disable iff (rst) // R5
    !frameStart |=> $stable(gainActive)) else $error("gain changed outside frame start");
  a_fine_max: assert property (@(posedge mclk) disable iff (rst) // R11
    mode60 && $stable(mode60) && frameStart |=> fineActive <= aec_pkg::FINE_MAX_60)
    else $error("fine above 60Hz maximum");
  a_coarse_max: assert property (@(posedge mclk) disable iff (rst) // R12
    frameStart |=> coarseActive <= aec_pkg::COARSE_MAX) else $error("coarse above maximum");
  a_read_back: assert property (@(posedge mclk) disable iff (rst) // R6
    regWrite && regAddr == aec_pkg::COARSE_OFFSET ##1 regAddr == aec_pkg::COARSE_OFFSET
    && !regWrite |=> regRdata == $past(regWdata, 2)) else $error("read back mismatch");
  a_auto_gain: assert property (@(posedge mclk) disable iff (rst) // R14
    frameStart && autoGainEn && !s_q.gainStageNew && gainActive[0] == gainActive[1]
    && gainActive[1] >= gainActive[2] |=> gainActive inside {3'h0, 3'h1, 3'h3, 3'h7})
    else $error("non thermometer automatic gain");
  a_pend_clear: assert property (@(posedge mclk) disable iff (rst) // R16
    !statusReg[0] && !regWrite |=> !statusReg[0]) else $error("pending set without write");
  a_clamp_fine: assert property (@(posedge mclk) disable iff (rst) // R10
    frameStart && autoExpEn && clampEn && nextCoarse > clampCoarse && !s_q.fineNew
    |=> fineActive <= $past(clampFine)) else $error("fine not clamped");
  c_auto_gain: cover property (@(posedge mclk) disable iff (rst)
    frameStart && autoExpEn && autoGainEn);
  c_write_fine: cover property (@(posedge mclk) disable iff (rst)
    regWrite && regAddr == aec_pkg::FINE_OFFSET ##[1:50] frameStart);
  c_gain_stage: cover property (@(posedge mclk) disable iff (rst)
    s_q.gainStageNew && frameStart);
  c_clamp: cover property (@(posedge mclk) disable iff (rst)
    frameStart && autoExpEn && clampEn && nextCoarse > clampCoarse);
endmodule

/* File: aec_host_model.sv */
// Host model that owns the exposure register port and the control levels other than clampEn.
`timescale 1ns/1ns
module aec_host_model (
  input wire logic mclk,
  output logic regWrite,
  output logic [6:0] regAddr,
  output logic [7:0] regWdata,
  output logic autoExpEn,
  output logic autoGainEn,
  output logic mode60,
  output logic [1:0] clkDivisor
);
  initial begin
    regWrite = 1'b0;
    regAddr = 7'h00;
    regWdata = 8'h00;
    autoExpEn = 1'b0;
    autoGainEn = 1'b0;
    mode60 = 1'b0;
    clkDivisor = 2'h0;
  end

  // Automatic control of the target is dropped first, so a write never races the algorithm.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    if (a == aec_pkg::GAIN_OFFSET) autoGainEn = 1'b0;
    if (a == aec_pkg::FINE_OFFSET || a == aec_pkg::COARSE_OFFSET) autoExpEn = 1'b0;
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(posedge mclk);
    #1;
    regWrite = 1'b0;
    // Released data shows the inverse so that a stale value is never mistaken for data.
    regWdata = ~d;
    // One idle edge keeps the strobe from rising again in the step that lowered it.
    @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [6:0] a);
    regAddr = a;
    @(posedge mclk);
    #1;
  endtask
endmodule

/* File: auto_exposure_control_tb.sv */
// Self-checking testbench for the exposure controller.
`timescale 1ns/1ns
module auto_exposure_control_tb;
  logic mclk, rst, frameStart, pixValid, clampEn, pixEn, regWrite, autoExpEn, autoGainEn, mode60;
  logic [6:0] regAddr;
  logic [7:0] regWdata, regRdata, pixData, fineActive, coarseActive, statusReg, v, per, gexp;
  logic [2:0] gainActive;
  logic [3:0] regionFlags;
  logic [7:0] pixFix;
  logic forcePix;
  logic [1:0] clkDivisor;
  int error_cnt, check_count, c;
  int selQ[$];
  logic [7:0] expQ[$];
  event chk;

  aec_host_model u_host (.mclk(mclk), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata), .autoExpEn(autoExpEn), .autoGainEn(autoGainEn), .mode60(mode60),
    .clkDivisor(clkDivisor));

  aec_core u_dut (.mclk(mclk), .rst(rst), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .frameStart(frameStart), .pixValid(pixValid),
    .pixData(pixData), .autoExpEn(autoExpEn), .autoGainEn(autoGainEn), .clampEn(clampEn),
    .mode60(mode60), .clkDivisor(clkDivisor), .lowerThr(aec_pkg::LOWER_THR_RESET),
    .centreThr(aec_pkg::CENTRE_THR_RESET), .higherThr(aec_pkg::HIGHER_THR_RESET),
    .clampCoarse(aec_pkg::CLAMP_COARSE_DEF), .clampFine(aec_pkg::CLAMP_FINE_DEF),
    .fineActive(fineActive), .coarseActive(coarseActive), .gainActive(gainActive),
    .statusReg(statusReg), .regionFlags(regionFlags), .pixEn(pixEn));

  always #4 mclk = ~mclk;

  always @(posedge mclk) begin
    #1;
    pixValid = forcePix | 1'($urandom);
    pixData = forcePix ? pixFix : 8'($urandom);
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic note(input int s, input logic [7:0] e);
    selQ.push_back(s);
    expQ.push_back(e);
    ->chk;
  endtask

  function automatic logic [7:0] obs(input int s);
    case (s)
      0: obs = fineActive;
      1: obs = coarseActive;
      2: obs = {5'h00, gainActive};
      3: obs = statusReg;
      4: obs = regRdata;
      6: obs = {4'h0, regionFlags};
      default: obs = per;
    endcase
  endfunction

  // Values are only read here, after the driver has stepped past the edge.
  always @(chk) begin
    while (selQ.size() > 0) begin
      check(obs(selQ.pop_front()), expQ.pop_front());
    end
  end

  task automatic frame();
    frameStart = 1'b1;
    @(posedge mclk);
    #1;
    frameStart = 1'b0;
    @(posedge mclk);
    #1;
  endtask

  // Pixels change together with the opening frame start, so the measured frame holds one region only.
  task automatic expose(input logic [7:0] p);
    pixFix = p;
    frame();
    u_host.autoExpEn = 1'b1;
    repeat (40) @(posedge mclk);
    #1;
    frame();
  endtask

  task automatic waitpix();
    c = 0;
    do begin
      @(posedge mclk);
      #1;
      c++;
    end while (pixEn !== 1'b1 && c < 40);
    if (c >= 40) begin
      error_cnt++;
      results();
    end
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    frameStart = 1'b0;
    pixValid = 1'b0;
    pixData = 8'h00;
    clampEn = 1'b0;
    per = 8'h00;
    gexp = 8'h00;
    forcePix = 1'b0;
    pixFix = 8'h00;
    void'($urandom(32'hc9d9a46a));
    repeat (5) @(posedge mclk);
    #1;
    rst = 1'b0;
    note(0, aec_pkg::FINE_RESET);
    note(1, aec_pkg::COARSE_RESET);
    note(2, {5'h00, aec_pkg::GAIN_RESET});
    note(3, 8'h00);
    note(6, 8'h00);
    v = 8'($urandom);
    u_host.wr(aec_pkg::FINE_OFFSET, ~v);
    u_host.wr(aec_pkg::FINE_OFFSET, v);
    note(3, 8'h01);
    u_host.rd(aec_pkg::FINE_OFFSET);
    note(4, v);
    note(0, aec_pkg::FINE_RESET);
    frame();
    note(0, v);
    note(3, 8'h00);
    u_host.wr(aec_pkg::COARSE_OFFSET, 8'ha0);
    note(1, aec_pkg::COARSE_RESET);
    frame();
    note(1, aec_pkg::COARSE_MAX);
    u_host.mode60 = 1'b1;
    u_host.wr(aec_pkg::FINE_OFFSET, 8'hff);
    frame();
    note(0, aec_pkg::FINE_MAX_60);
    u_host.mode60 = 1'b0;
    for (int g = 0; g < 8; g++) begin
      u_host.wr(aec_pkg::GAIN_OFFSET, 8'(7 - g));
      frame();
      note(2, gexp);
      note(3, 8'h01);
      gexp = 8'(7 - g);
      frame();
      note(2, gexp);
      note(3, 8'h00);
    end
    u_host.autoExpEn = 1'b1;
    u_host.wr(aec_pkg::GAIN_OFFSET, 8'h05);
    frame();
    frame();
    note(2, 8'h05);
    u_host.wr(7'h22, 8'h5a);
    u_host.rd(7'h22);
    note(4, 8'h00);
    note(3, 8'h00);
    for (int n = 0; n < 4; n++) begin
      u_host.clkDivisor = 2'(n);
      waitpix();
      waitpix();
      waitpix();
      per = 8'(c);
      note(5, 8'(1 << (n + 1)));
    end
    u_host.clkDivisor = 2'h0;
    forcePix = 1'b1;
    u_host.wr(aec_pkg::FINE_OFFSET, 8'h10);
    u_host.wr(aec_pkg::COARSE_OFFSET, 8'h20);
    expose(8'hf0);
    note(0, 8'h0f);
    note(6, 8'h01);
    expose(8'h10);
    note(0, 8'h10);
    note(6, 8'h08);
    clampEn = 1'b1;
    u_host.wr(aec_pkg::COARSE_OFFSET, 8'h85);
    expose(8'h10);
    note(0, aec_pkg::CLAMP_FINE_DEF);
    clampEn = 1'b0;
    u_host.autoGainEn = 1'b1;
    u_host.wr(aec_pkg::FINE_OFFSET, 8'hff);
    u_host.wr(aec_pkg::COARSE_OFFSET, aec_pkg::COARSE_MAX);
    expose(8'h10);
    note(2, 8'h03);
    note(0, aec_pkg::FINE_MAX_50);
    note(1, aec_pkg::COARSE_MAX);
    #2;
    results();
  end
endmodule
